//--- prc_pkg.sv
// package: constants, types and map of the pulse reference / run command block
// ============================================================================
// Summary of operation
// [RL1] pulse train on selectable input gives reference
// [RL2] count frequency, then pass value downstream
// [RL3] use selector routes reference to one destination
// [RL4] two frequency points, 10 to 60 Hz
// [RL5] points map to min and max values
// [RL6] frequency uses in hertz, others in percent
// [RL7] filter time 0 to 30 s, zero bypasses
// [RL8] six base plus eight optional command inputs
// [RL9] safe standstill input fixed, high level only
// [RL10] fieldbus bits and timer outputs drive functions
// [RL11] refuse double assignment, keep old, raise alarm
// [RL12] code 1: high runs forward, low stops
// [RL13] code 2: high runs reverse, low stops
// [RL14] code 3: rising edge starts forward
// [RL15] code 4: rising edge starts reverse
// [RL16] code 0: input has no effect
// [RL17] 3-wire stop held high, falling edge stops
// [RL18] clamp output outside the frequency points
// [RL19] synchronise inputs, edges from previous sample
package prc_pkg;
  // ==========================================================================
  // timing
  localparam int CLK_HZ           = 50_000_000;
  localparam int GATE_TIME_MS     = 1000;
  localparam int GATE_CYCLES_DFLT = CLK_HZ / 1000 * GATE_TIME_MS;
  localparam int TICK_TIME_US     = 1000;
  localparam int TICK_CYCLES_DFLT = CLK_HZ / 1_000_000 * TICK_TIME_US;
  localparam int FILT_UNIT_MS     = 100;
  localparam int FILT_STEPS       = FILT_UNIT_MS * 1000 / TICK_TIME_US;
  localparam int FRAC_W           = 16;
  // ==========================================================================
  // sizes
  localparam int N_DI  = 14;
  localparam int N_CW  = 8;
  localparam int N_TMR = 2;
  localparam int N_SRC = N_DI + N_CW + N_TMR;
  localparam int SRC_W = 5;
  localparam int N_FN  = 5;
  localparam int N_DST = 6;
  localparam int N_IRQ = 4;
  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_FREQ_LO  = 8'h04;
  localparam logic [7:0] ADR_FREQ_HI  = 8'h08;
  localparam logic [7:0] ADR_VAL_LO   = 8'h0C;
  localparam logic [7:0] ADR_VAL_HI   = 8'h10;
  localparam logic [7:0] ADR_FILT     = 8'h14;
  localparam logic [7:0] ADR_MEAS     = 8'h18;
  localparam logic [7:0] ADR_REF      = 8'h1C;
  localparam logic [7:0] ADR_ASSIGN   = 8'h20;
  localparam logic [7:0] ADR_HOLDERS  = 8'h24;
  localparam logic [7:0] ADR_CWORD    = 8'h28;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h2C;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h30;
  localparam logic [7:0] ADR_RUN      = 8'h34;
  // ==========================================================================
  // fields, reset values, limits
  localparam int CTRL_USE_LSB  = 0;
  localparam int CTRL_PSRC_LSB = 4;
  localparam int ASG_FN_LSB    = 0;
  localparam int ASG_SRC_LSB   = 8;
  localparam int HOLD_W        = 6;
  localparam logic [15:0] FREQ_LO_RST = 16'h000A;
  localparam logic [15:0] FREQ_HI_RST = 16'h003C;
  localparam logic [15:0] VAL_LO_RST  = 16'h0000;
  localparam logic [15:0] VAL_HI_RST  = 16'h0032;
  localparam logic [15:0] FILT_RST    = 16'h0000;
  localparam logic [15:0] FREQ_MIN    = 16'h000A;
  localparam logic [15:0] FREQ_MAX    = 16'h003C;
  localparam logic signed [15:0] VAL_MIN = -16'sh012C;
  localparam logic signed [15:0] VAL_MAX = 16'sh012C;
  localparam logic [15:0] FILT_MAX    = 16'h012C;
  // ==========================================================================
  // codes and bit positions
  typedef enum logic [3:0] {
    USE_NONE = 4'h0, USE_FREF1 = 4'h1, USE_FREF2 = 4'h2, USE_FCORR = 4'h3,
    USE_PID_SP = 4'h6, USE_PID_FB = 4'h7, USE_REQUEST = 4'hF
  } prc_use_t;
  typedef enum logic [2:0] {
    FN_NONE = 3'h0, FN_LVL_FWD = 3'h1, FN_LVL_REV = 3'h2,
    FN_EDGE_FWD = 3'h3, FN_EDGE_REV = 3'h4, FN_STOP3 = 3'h5
  } prc_fn_t;
  localparam int DST_FREF1 = 0;
  localparam int DST_FREF2 = 1;
  localparam int DST_FCORR = 2;
  localparam int DST_PIDSP = 3;
  localparam int DST_PIDFB = 4;
  localparam int DST_REQ   = 5;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_MEAS  = 1;
  localparam int IRQ_RUN   = 2;
  localparam int IRQ_STOP  = 3;
  // ==========================================================================
  // carriers
  typedef struct packed {
    logic signed [15:0] value;
    logic [N_DST-1:0]   dest;
    logic               unit_hz;
  } prc_ref_t;
  typedef struct packed {
    logic fwd;
    logic rev;
  } prc_run_t;
endpackage

//--- prc_top.sv
// pulse frequency reference and digital run command decoder
`timescale 1ns/1ns
module prc_top import prc_pkg::*; #(
  parameter int GATE_CYCLES = GATE_CYCLES_DFLT,
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
  // system
  input  wire logic              clk,
  input  wire logic              reset,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // terminals, index 0 is cmd_input_first
  input  wire logic [N_DI-1:0]   cmd_inputs,
  input  wire logic              safe_standstill_input,
  // timer module outputs, same clock
  input  wire logic [N_TMR-1:0]  timer_out,
  // results
  output prc_ref_t               pulse_freq_reference,
  output prc_run_t               run_cmd,
  output logic                   irq
);

  // ==========================================================================
  // bus access
  logic                          ack;
  wire  acc = wb_cyc_i & wb_stb_i & ~ack;
  wire  wr  = acc & wb_we_i;
  wire  hit_ctrl  = wb_adr_i == ADR_CTRL;
  wire  hit_flo   = wb_adr_i == ADR_FREQ_LO;
  wire  hit_fhi   = wb_adr_i == ADR_FREQ_HI;
  wire  hit_vlo   = wb_adr_i == ADR_VAL_LO;
  wire  hit_vhi   = wb_adr_i == ADR_VAL_HI;
  wire  hit_filt  = wb_adr_i == ADR_FILT;
  wire  hit_meas  = wb_adr_i == ADR_MEAS;
  wire  hit_ref   = wb_adr_i == ADR_REF;
  wire  hit_asg   = wb_adr_i == ADR_ASSIGN;
  wire  hit_hold  = wb_adr_i == ADR_HOLDERS;
  wire  hit_cw    = wb_adr_i == ADR_CWORD;
  wire  hit_stat  = wb_adr_i == ADR_IRQ_STAT;
  wire  hit_mask  = wb_adr_i == ADR_IRQ_MASK;
  wire  hit_run   = wb_adr_i == ADR_RUN;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // ==========================================================================
  // settings
  logic [3:0]             use_sel;
  logic [3:0]             pulse_src;
  logic [15:0]            flo;
  logic [15:0]            fhi;
  logic signed [15:0]     vlo;
  logic signed [15:0]     vhi;
  logic [15:0]            filt_time;
  logic [N_CW-1:0]        cword;
  logic [N_IRQ-1:0]       irq_mask;
  logic [N_IRQ-1:0]       irq_stat;

  wire  [15:0] w_ctrl = merge16({8'h00, pulse_src, use_sel}, wb_dat_i,
                                wb_sel_i);
  wire  [15:0] w_flo  = merge16(flo, wb_dat_i, wb_sel_i);
  wire  [15:0] w_fhi  = merge16(fhi, wb_dat_i, wb_sel_i);
  wire  [15:0] w_vlo  = merge16(vlo, wb_dat_i, wb_sel_i);
  wire  [15:0] w_vhi  = merge16(vhi, wb_dat_i, wb_sel_i);
  wire  [15:0] w_filt = merge16(filt_time, wb_dat_i, wb_sel_i);
  wire  psrc_ok = w_ctrl[CTRL_PSRC_LSB+:4] < 4'(N_DI);
  wire  flo_ok  = w_flo >= FREQ_MIN && w_flo <= FREQ_MAX;
  wire  fhi_ok  = w_fhi >= FREQ_MIN && w_fhi <= FREQ_MAX;
  wire  vlo_ok  = $signed(w_vlo) >= VAL_MIN && $signed(w_vlo) <= VAL_MAX;
  wire  vhi_ok  = $signed(w_vhi) >= VAL_MIN && $signed(w_vhi) <= VAL_MAX;
  wire  filt_ok = w_filt <= FILT_MAX;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      use_sel   <= USE_NONE;
      pulse_src <= 4'h0;
      flo       <= FREQ_LO_RST;
      fhi       <= FREQ_HI_RST;
      vlo       <= VAL_LO_RST;
      vhi       <= VAL_HI_RST;
      filt_time <= FILT_RST;
      cword     <= '0;
      irq_mask  <= '0;
    end else if (wr) begin
      if (hit_ctrl && psrc_ok) begin
        use_sel   <= w_ctrl[CTRL_USE_LSB+:4]; // RL3
        pulse_src <= w_ctrl[CTRL_PSRC_LSB+:4]; // RL1
      end
      if (hit_flo && flo_ok) flo <= w_flo; // RL4
      if (hit_fhi && fhi_ok) fhi <= w_fhi; // RL4
      if (hit_vlo && vlo_ok) vlo <= w_vlo; // RL5
      if (hit_vhi && vhi_ok) vhi <= w_vhi; // RL5
      if (hit_filt && filt_ok) filt_time <= w_filt; // RL7
      if (hit_cw && wb_sel_i[0]) cword <= wb_dat_i[N_CW-1:0]; // RL10
      if (hit_mask && wb_sel_i[0]) irq_mask <= wb_dat_i[N_IRQ-1:0];
    end
  end

  // ==========================================================================
  // input synchronisers
  logic [N_DI:0]          pin_s1;
  logic [N_DI:0]          pin_s2;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {safe_standstill_input, cmd_inputs}; // RL19
      pin_s2 <= pin_s1; // RL19
    end
  end
  wire  [N_DI-1:0] di_sync = pin_s2[N_DI-1:0]; // RL8
  wire  safe_ok = pin_s2[N_DI]; // RL9

  // ==========================================================================
  // pulse frequency count over a fixed gate
  logic                   pulse_prev;
  logic [31:0]            gate_cnt;
  logic [15:0]            edge_cnt;
  logic [15:0]            freq_meas;
  logic                   meas_done;
  wire  pulse_now  = di_sync[pulse_src];
  wire  pulse_rise = pulse_now & ~pulse_prev;
  wire  gate_end   = gate_cnt == 32'(GATE_CYCLES - 1);
  wire  [15:0] edge_next = edge_cnt + 16'(pulse_rise);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pulse_prev <= 1'b0;
      gate_cnt   <= '0;
      edge_cnt   <= '0;
      freq_meas  <= '0;
      meas_done  <= 1'b0;
    end else begin
      pulse_prev <= pulse_now; // RL1
      meas_done  <= gate_end;
      gate_cnt   <= gate_end ? '0 : gate_cnt + 32'h0000_0001;
      edge_cnt   <= gate_end ? '0 : edge_next;
      if (gate_end) freq_meas <= edge_next; // RL2
    end
  end

  // ==========================================================================
  // linear scaling between the two frequency/value pairs
  wire  signed [31:0] f_s    = $signed({16'h0000, freq_meas});
  wire  signed [31:0] flo_s  = $signed({16'h0000, flo});
  wire  signed [31:0] fhi_s  = $signed({16'h0000, fhi});
  wire  signed [31:0] vlo_s  = 32'(vlo);
  wire  signed [31:0] vhi_s  = 32'(vhi);
  wire  signed [31:0] span   = fhi_s - flo_s;
  wire  signed [31:0] span_d = span > 0 ? span : 32'sh0000_0001;
  wire  signed [31:0] interp = vlo_s + ((f_s - flo_s) * (vhi_s - vlo_s))
                               / span_d;
  wire  below = f_s <= flo_s;
  wire  above = f_s >= fhi_s;
  wire  signed [15:0] scaled = below ? vlo :
                               above ? vhi : interp[15:0]; // RL5 RL18

  // ==========================================================================
  // first-order filter stepped once per tick
  logic [31:0]            tick_cnt;
  logic signed [31:0]     acc_f;
  wire  tick = tick_cnt == 32'(TICK_CYCLES - 1);
  wire  signed [31:0] x_f    = 32'(scaled) <<< FRAC_W;
  wire  signed [31:0] tau    = $signed({16'h0000, filt_time}) * FILT_STEPS;
  wire  signed [31:0] tau_d  = tau > 0 ? tau : 32'sh0000_0001;
  wire  signed [31:0] step_f = (x_f - acc_f) / tau_d;
  wire  filt_off = filt_time == FILT_RST;
  wire  signed [15:0] filt_out = 16'(acc_f >>> FRAC_W);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt <= '0;
      acc_f    <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 32'h0000_0001;
      if (filt_off) acc_f <= x_f; // RL7
      else if (tick) acc_f <= acc_f + step_f; // RL7
    end
  end

  // ==========================================================================
  // routing to the selected use
  logic [N_DST-1:0]       dest_hot;
  assign dest_hot[DST_FREF1] = use_sel == USE_FREF1;
  assign dest_hot[DST_FREF2] = use_sel == USE_FREF2;
  assign dest_hot[DST_FCORR] = use_sel == USE_FCORR;
  assign dest_hot[DST_PIDSP] = use_sel == USE_PID_SP;
  assign dest_hot[DST_PIDFB] = use_sel == USE_PID_FB;
  assign dest_hot[DST_REQ]   = use_sel == USE_REQUEST;
  wire  unit_hz = dest_hot[DST_FREF1] | dest_hot[DST_FREF2] |
                  dest_hot[DST_FCORR];
  wire  signed [15:0] ref_val = filt_off ? scaled : filt_out;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pulse_freq_reference <= '0;
    end else begin
      pulse_freq_reference.value   <= ref_val; // RL2 RL7
      pulse_freq_reference.dest    <= dest_hot; // RL3
      pulse_freq_reference.unit_hz <= unit_hz; // RL6
    end
  end

  // ==========================================================================
  // function assignment table: one holder per function
  logic [SRC_W-1:0]       holder_src [N_FN];
  logic [N_FN-1:0]        holder_ok;
  wire  [2:0]       asg_fn  = wb_dat_i[ASG_FN_LSB+:3];
  wire  [SRC_W-1:0] asg_src = wb_dat_i[ASG_SRC_LSB+:SRC_W];
  wire  asg_wr  = wr && hit_asg && wb_sel_i[1:0] == 2'b11;
  wire  asg_bad = asg_src >= SRC_W'(N_SRC) || asg_fn > FN_STOP3;
  wire  [2:0] asg_idx = asg_fn - 3'h1;
  wire  conflict = asg_fn != FN_NONE && !asg_bad && holder_ok[asg_idx]
                   && holder_src[asg_idx] != asg_src; // RL11
  wire  asg_take = asg_wr && !asg_bad && !conflict;
  wire  alarm_ev = asg_wr && conflict;

  wire  [N_SRC-1:0] src_cur = {timer_out, cword, di_sync}; // RL10
  logic [N_FN-1:0]        fn_level;
  logic [N_FN-1:0]        fn_prev;
  logic [N_FN*HOLD_W-1:0] hold_view;

  genvar k;
  generate
    for (k = 0; k < N_FN; k++) begin : g_fn
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          holder_ok[k]  <= 1'b0;
          holder_src[k] <= '0;
        end else if (asg_take) begin
          if (asg_fn == 3'(k + 1)) begin
            holder_ok[k]  <= 1'b1; // RL11
            holder_src[k] <= asg_src;
          end else if (holder_src[k] == asg_src) begin
            holder_ok[k]  <= 1'b0; // RL16
          end
        end
      end
      assign fn_level[k] = holder_ok[k] & src_cur[holder_src[k]]; // RL16
      assign hold_view[k*HOLD_W+:HOLD_W] = {holder_ok[k], holder_src[k]};
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) fn_prev <= '0;
    else fn_prev <= fn_level; // RL19
  end
  wire  [N_FN-1:0] fn_rise = fn_level & ~fn_prev; // RL19
  wire  [N_FN-1:0] fn_fall = ~fn_level & fn_prev;

  // ==========================================================================
  // run decision: 2-wire levels, 3-wire edges and stop
  localparam int IX_LF = 0;
  localparam int IX_LR = 1;
  localparam int IX_EF = 2;
  localparam int IX_ER = 3;
  localparam int IX_ST = 4;
  logic                   fwd3;
  logic                   rev3;
  wire  stop3_ok = fn_level[IX_ST]; // RL17
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fwd3 <= 1'b0;
      rev3 <= 1'b0;
    end else if (!safe_ok || !stop3_ok) begin
      fwd3 <= 1'b0; // RL17
      rev3 <= 1'b0;
    end else if (fn_rise[IX_EF]) begin
      fwd3 <= 1'b1; // RL14
      rev3 <= 1'b0;
    end else if (fn_rise[IX_ER]) begin
      fwd3 <= 1'b0;
      rev3 <= 1'b1; // RL15
    end
  end

  wire  req_f = (fn_level[IX_LF] & ~fn_level[IX_LR]) | fwd3; // RL12
  wire  req_r = (fn_level[IX_LR] & ~fn_level[IX_LF]) | rev3; // RL13
  prc_run_t next_run;
  assign next_run.fwd = safe_ok & req_f & ~req_r; // RL9
  assign next_run.rev = safe_ok & req_r & ~req_f; // RL9
  wire  running = run_cmd.fwd | run_cmd.rev;
  wire  run_ev  = ~running & (next_run.fwd | next_run.rev);
  wire  stop_ev = running & ~(next_run.fwd | next_run.rev);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) run_cmd <= '0;
    else run_cmd <= next_run;
  end

  // ==========================================================================
  // interrupts: sticky, write one to clear, set wins
  wire  [N_IRQ-1:0] irq_set;
  assign irq_set[IRQ_ALARM] = alarm_ev; // RL11
  assign irq_set[IRQ_MEAS]  = meas_done;
  assign irq_set[IRQ_RUN]   = run_ev;
  assign irq_set[IRQ_STOP]  = stop_ev;
  wire  [N_IRQ-1:0] irq_clr = (wr && hit_stat && wb_sel_i[0]) ?
                              wb_dat_i[N_IRQ-1:0] : '0;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) irq_stat <= '0;
    else irq_stat <= (irq_stat & ~irq_clr) | irq_set;
  end
  assign irq = |(irq_stat & irq_mask);

  // ==========================================================================
  // read data and acknowledge
  wire  [31:0] rd_data =
    hit_ctrl ? {24'h0, pulse_src, use_sel} :
    hit_flo  ? {16'h0, flo} :
    hit_fhi  ? {16'h0, fhi} :
    hit_vlo  ? {{16{vlo[15]}}, vlo} :
    hit_vhi  ? {{16{vhi[15]}}, vhi} :
    hit_filt ? {16'h0, filt_time} :
    hit_meas ? {16'h0, freq_meas} :
    hit_ref  ? {{16{pulse_freq_reference.value[15]}},
                pulse_freq_reference.value} :
    hit_hold ? 32'(hold_view) :
    hit_cw   ? 32'(cword) :
    hit_stat ? 32'(irq_stat) :
    hit_mask ? 32'(irq_mask) :
    hit_run  ? {29'h0, safe_ok, run_cmd.rev, run_cmd.fwd} :
    32'h0000_0000;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack      <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack <= acc;
      if (acc && !wb_we_i) wb_dat_o <= rd_data;
    end
  end
  assign wb_ack_o = ack;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_fwd_edge;
    safe_ok && stop3_ok && fn_rise[IX_EF];
  endsequence
  sequence s_rev_edge;
    safe_ok && stop3_ok && fn_rise[IX_ER] && !fn_rise[IX_EF];
  endsequence
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_sync_two_ff: assert property (##2 di_sync == $past(cmd_inputs, 2)) // RL19
    else $error("command input not delayed by two flops");
  a_meas_latch: assert property (gate_end |=> freq_meas == $past(edge_next)) // RL2
    else $error("measured frequency not latched at gate end");
  a_clamp_low: assert property (filt_off && freq_meas <= flo |=> // RL18
    pulse_freq_reference.value == $past(vlo))
    else $error("scaled value not clamped to minimum");
  a_clamp_high: assert property (filt_off && freq_meas >= fhi && // RL18
    freq_meas > flo |=> pulse_freq_reference.value == $past(vhi))
    else $error("scaled value not clamped to maximum");
  a_route_unit: assert property (##1 pulse_freq_reference.unit_hz == // RL6
    $past(use_sel == USE_FREF1 || use_sel == USE_FREF2 ||
          use_sel == USE_FCORR))
    else $error("unit flag does not follow use");
  a_route_dest: assert property (use_sel == USE_NONE |=> // RL3
    pulse_freq_reference.dest == '0)
    else $error("reference routed while use is none");
  a_filter_bypass: assert property (filt_off |=> // RL7
    pulse_freq_reference.value == $past(scaled))
    else $error("zero filter time does not bypass");
  a_refuse_dup: assert property (alarm_ev |=> // RL11
    irq_stat[IRQ_ALARM] && holder_src[$past(asg_idx)] ==
    $past(holder_src[asg_idx]))
    else $error("double assignment not refused");
  a_level_fwd: assert property (safe_ok && fn_level[IX_LF] && // RL12
    !fn_level[IX_LR] && !rev3 |=> run_cmd.fwd)
    else $error("2-wire forward level did not run");
  a_level_rev: assert property (safe_ok && fn_level[IX_LR] && // RL13
    !fn_level[IX_LF] && !fwd3 |=> run_cmd.rev)
    else $error("2-wire reverse level did not run");
  a_edge_fwd: assert property (s_fwd_edge |=> fwd3 && !rev3) // RL14
    else $error("3-wire forward edge not latched");
  a_edge_rev: assert property (s_rev_edge |=> rev3 && !fwd3) // RL15
    else $error("3-wire reverse edge not latched");
  a_unused_fn: assert property (!holder_ok[IX_LF] |-> !fn_level[IX_LF]) // RL16
    else $error("unassigned function is active");
  a_stop_fall: assert property (fn_fall[IX_ST] |=> !fwd3 && !rev3) // RL17
    else $error("3-wire stop edge did not stop");
  a_safe_stop: assert property (!safe_ok |=> !run_cmd.fwd && !run_cmd.rev) // RL9
    else $error("run commanded without safe input");
endmodule

//--- prc_ctrl_model.sv
// upstream control system model driving the command terminals
`timescale 1ns/1ns
module prc_ctrl_model import prc_pkg::*; (
  // system
  input  wire logic            clk,
  // settings from the bench
  input  wire logic [N_DI-1:0] level,
  input  wire logic            safe_on,
  input  wire logic            pulse_on,
  input  wire logic [3:0]      pulse_pin,
  // terminals
  output logic      [N_DI-1:0] cmd_inputs,
  output logic                 safe_standstill_input
);
  // ==========================================================================
  // pulse train, period 40 cycles
  logic [4:0] cnt;
  logic       ph;
  initial begin
    cnt = 5'h00;
    ph = 1'b0;
    cmd_inputs = '0;
    safe_standstill_input = 1'b0;
  end
  always @(posedge clk) begin
    cnt <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
    if (cnt == 5'h13) begin
      ph <= ~ph;
    end
    // levels only change just after an edge; stop held by the bench
    cmd_inputs <= level | (N_DI'(pulse_on & ph) << pulse_pin);
    safe_standstill_input <= safe_on;
  end
endmodule

//--- pulse_reference_and_run_command_inputs_test.sv
// self-checking bench of the pulse reference and run command block
`timescale 1ns/1ns
module pulse_reference_and_run_command_inputs_test import prc_pkg::*;;
  // ==========================================================================
  // signals
  logic clk, reset, cyc, stb, we, ack, irq, safe, pen;
  logic [7:0] adr;
  logic [3:0] sel, pin;
  logic [31:0] dat, dat_o, q;
  logic [N_DI-1:0] lvl, di;
  logic [N_TMR-1:0] tmr;
  logic sdi;
  prc_ref_t rf;
  prc_run_t run;
  int n_errors, checks_done;
  logic [3:0] uc [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hF};
  logic [6:0] ue [7] = '{7'h00, 7'h03, 7'h05, 7'h09, 7'h10, 7'h20, 7'h40};
  always #10 clk = ~clk;
  prc_top #(.GATE_CYCLES(1000), .TICK_CYCLES(10)) dut (.clk(clk),
    .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .cmd_inputs(di), .safe_standstill_input(sdi),
    .timer_out(tmr), .pulse_freq_reference(rf), .run_cmd(run), .irq(irq));
  prc_ctrl_model far (.clk(clk), .level(lvl), .safe_on(safe),
    .pulse_on(pen), .pulse_pin(pin), .cmd_inputs(di),
    .safe_standstill_input(sdi));
  // ==========================================================================
  // tasks
  task conclude;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'h3;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED t=%0t bus timeout", $time);
      conclude();
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ==========================================================================
  // sequence
  initial begin
    clk = 0; reset = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0;
    dat = 0; lvl = 0; safe = 1; pen = 0; pin = 4'h7; tmr = 0;
    n_errors = 0; checks_done = 0;
    idle(3);
    reset <= 1'b0;
    wb(0, ADR_FREQ_LO, 0); chk(q, 32'h0000000A);
    wb(0, ADR_FREQ_HI, 0); chk(q, 32'h0000003C);
    wb(0, ADR_VAL_HI, 0); chk(q, 32'h00000032);
    wb(0, 8'hFC, 0); chk(q, 32'h00000000);
    wb(1, ADR_ASSIGN, 32'h0001); lvl[0] <= 1'b1; idle(6);
    chk(32'(run), 32'h2);
    lvl[0] <= 1'b0; idle(6); chk(32'(run), 32'h0);
    wb(1, ADR_IRQ_MASK, 32'h1); wb(1, ADR_ASSIGN, 32'h0101); idle(2);
    chk(32'(irq), 32'h1);
    wb(0, ADR_HOLDERS, 0); chk(q & 32'h3F, 32'h20);
    wb(1, ADR_IRQ_STAT, 32'h1); idle(2); chk(32'(irq), 32'h0);
    wb(1, ADR_ASSIGN, 32'h0E02); wb(1, ADR_CWORD, 32'h1); idle(4);
    chk(32'(run), 32'h1);
    safe <= 1'b0; idle(6); chk(32'(run), 32'h0);
    safe <= 1'b1; wb(1, ADR_CWORD, 32'h0);
    wb(1, ADR_ASSIGN, 32'h0000); lvl[0] <= 1'b1; idle(6);
    chk(32'(run), 32'h0);
    wb(1, ADR_ASSIGN, 32'h0305); wb(1, ADR_ASSIGN, 32'h0403);
    wb(1, ADR_ASSIGN, 32'h0504); lvl <= 14'h0008; idle(6);
    chk(32'(run), 32'h0);
    lvl[4] <= 1'b1; idle(6); chk(32'(run), 32'h2);
    lvl[4] <= 1'b0; idle(6); chk(32'(run), 32'h2);
    lvl[3] <= 1'b0; idle(6); chk(32'(run), 32'h0);
    lvl[3] <= 1'b1; idle(6); lvl[5] <= 1'b1; idle(6);
    chk(32'(run), 32'h1);
    lvl <= '0;
    wb(1, ADR_CTRL, 32'h71); pen <= 1'b1; idle(2100);
    wb(0, ADR_MEAS, 0); chk(q, 32'h19);
    wb(0, ADR_REF, 0); chk(q, 32'h0F);
    chk(32'(rf.value), 32'h0F);
    for (int i = 0; i < 7; i++) begin
      wb(1, ADR_CTRL, {24'h0, 4'h7, uc[i]}); idle(3);
      chk(32'({rf.dest, rf.unit_hz}), 32'(ue[i]));
    end
    wb(1, ADR_FREQ_HI, 32'h14); idle(2100);
    wb(0, ADR_REF, 0); chk(q, 32'h32);
    wb(1, ADR_ASSIGN, 32'h1601); tmr[0] <= 1'b1; idle(3);
    chk(32'(run), 32'h2);
    tmr[0] <= 1'b0; idle(3); chk(32'(run), 32'h0);
    wb(0, ADR_IRQ_STAT, 0); chk(q, 32'hE);
    wb(1, ADR_IRQ_STAT, 32'hC); wb(0, ADR_IRQ_STAT, 0);
    chk(q & 32'hD, 32'h0);
    wb(1, ADR_FILT, 32'h12C); wb(1, ADR_FREQ_HI, 32'h3C); idle(100);
    wb(0, ADR_REF, 0); chk(q, 32'h31);
    conclude();
  end
endmodule
